// File: shared/nvmac_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the access block
// Assumes: 8-bit I/O register port, 125 MHz CPU clock
// Notes: register offsets are local I/O indices
`ifndef NVMAC_MAP_SVH
`define NVMAC_MAP_SVH

// I/O register indices
`define NVMAC_OFF_ADDR_HI 2'h0
`define NVMAC_OFF_ADDR_LO 2'h1
`define NVMAC_OFF_DATA 2'h2
`define NVMAC_OFF_CTRL 2'h3

// Control register fields
`define NVMAC_BIT_READ 0
`define NVMAC_BIT_WRITE 1
`define NVMAC_BIT_MWE 2
`define NVMAC_BIT_RIE 3

// Timing counts
`define NVMAC_MWE_CYCLES 3'h4
`define NVMAC_WSTALL_CYCLES 3'h2
`define NVMAC_RSTALL_CYCLES 3'h4
`define NVMAC_WRITE_RC_CYCLES 2048

// Reset values
`define NVMAC_CTRL_RESET 8'h00
`define NVMAC_ZERO_BYTE 8'h00

`endif

// File: shared/nvmac_pkg.sv
// Purpose: types shared by the access block
// Assumes: nvmac_map.svh supplies numeric constants
// Notes: none
package nvmac_pkg;
    typedef enum logic [2:0] {
        NVMAC_IDLE = 3'b001,
        NVMAC_WRITING = 3'b010,
        NVMAC_READING = 3'b100
    } nvmac_state_t;

    typedef struct packed {
        logic [1:0] offset;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } nvmac_io_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } nvmac_array_t;
endpackage

// File: verilog/nvmac_rc_timer.sv
// Purpose: counts RC oscillator ticks for one self-timed write
// Assumes: rc_tick is a one-cycle enable synchronous to clk
// Notes: abort ends a write early
`timescale 1ns/10ps
`include "nvmac_map.svh"
module nvmac_rc_timer #(
    parameter int RC_CYCLES = `NVMAC_WRITE_RC_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic rc_tick,
    // Status
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(RC_CYCLES + 1);
    logic [CW-1:0] count;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= '0;
                busy <= 1'b1;
            end else if (abort) begin
                busy <= 1'b0;
            end else if (busy && rc_tick) begin
                if (count == CW'(RC_CYCLES - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                count <= count + 1'b1;
            end
        end
    end
endmodule

// File: verilog/nvmac_access.sv
// Purpose: CPU access control for a 512-byte on-chip nonvolatile array
// Assumes: I/O port strobes are synchronous one-cycle pulses; rc_tick paced by RC oscillator
// Notes: array itself lives outside; reads complete in one cycle
`timescale 1ns/10ps
`include "nvmac_map.svh"

// Overview of operation
// - Ready interrupt held while both enables set and write strobe reads zero.
// - Write strobe starts a write only when master write enable is set.
// - Master write enable clears itself four CPU clocks after being set.
// - Permitted write programs data register byte at address register location.
// - Write strobe holds one during write, clears when access time elapses.
// - Setting write strobe stalls the CPU for two clocks.
// - Read strobe fetches addressed byte into data register, then clears itself.
// - Setting read strobe stalls the CPU for four clocks.
// - Writing address or data during a write aborts it; result undefined.
// - Each write lasts 2048 RC oscillator cycles.
// - Control register bits seven to four always read zero.
// - Address register is nine bits, bytes 0 to 511, loaded before use.
module nvmac_access #(
    parameter int RC_CYCLES = `NVMAC_WRITE_RC_CYCLES,
    parameter int ADDR_W = 9
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // CPU I/O register port
    input wire nvmac_pkg::nvmac_io_t io_req,
    output logic [7:0] io_rdata,
    // CPU status and control
    input wire logic global_irq_enable,
    output logic cpu_stall,
    output logic ready_irq,
    // RC oscillator enable pulse
    input wire logic rc_tick,
    // Array side
    output nvmac_pkg::nvmac_array_t array_req,
    input wire logic [7:0] array_rdata
);
    logic [ADDR_W-1:0] nvm_address_reg;
    logic [7:0] nvm_data_reg;
    logic ready_irq_enable;
    logic master_write_enable;
    logic write_strobe;
    logic read_strobe;
    logic [2:0] mwe_count;
    logic [2:0] stall_count;
    nvmac_pkg::nvmac_state_t state;
    logic wr_ctrl;
    logic wr_addr;
    logic wr_data;
    logic start_write;
    logic start_read;
    logic timer_busy;
    logic timer_done;

    function automatic logic hit(input logic [1:0] off);
        hit = io_req.wr && (io_req.offset == off);
    endfunction

    assign wr_ctrl = hit(`NVMAC_OFF_CTRL);
    assign wr_addr = hit(`NVMAC_OFF_ADDR_HI) || hit(`NVMAC_OFF_ADDR_LO);
    assign wr_data = hit(`NVMAC_OFF_DATA);
    // Strobe ignored while a write already runs
    assign start_write = wr_ctrl && io_req.wdata[`NVMAC_BIT_WRITE] && master_write_enable
                         && !write_strobe;
    assign start_read = wr_ctrl && io_req.wdata[`NVMAC_BIT_READ] && !write_strobe;

    nvmac_rc_timer #(
        .RC_CYCLES(RC_CYCLES)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .start(start_write),
        .abort(wr_addr || wr_data),
        .rc_tick(rc_tick),
        .busy(timer_busy),
        .done(timer_done)
    );

    // Address register; undefined at reset in silicon, zero here for determinism
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nvm_address_reg <= '0;
        end else if (hit(`NVMAC_OFF_ADDR_HI)) begin
            nvm_address_reg[ADDR_W-1] <= io_req.wdata[0];
        end else if (hit(`NVMAC_OFF_ADDR_LO)) begin
            nvm_address_reg[7:0] <= io_req.wdata;
        end
    end

    // Data register: CPU write or read fetch
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nvm_data_reg <= `NVMAC_ZERO_BYTE;
        end else if (wr_data) begin
            nvm_data_reg <= io_req.wdata;
        end else if (state == nvmac_pkg::NVMAC_READING) begin
            nvm_data_reg <= array_rdata;
        end
    end

    // Control bits
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ready_irq_enable <= 1'b0;
            master_write_enable <= 1'b0;
            mwe_count <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                ready_irq_enable <= io_req.wdata[`NVMAC_BIT_RIE];
            end
            // Enable only accepted with write strobe written zero
            if (wr_ctrl && io_req.wdata[`NVMAC_BIT_MWE] && !io_req.wdata[`NVMAC_BIT_WRITE]) begin
                master_write_enable <= 1'b1;
                mwe_count <= 3'h0;
            end else if (master_write_enable) begin
                if (mwe_count == `NVMAC_MWE_CYCLES - 3'h1) begin
                    master_write_enable <= 1'b0;
                end
                mwe_count <= mwe_count + 3'h1;
            end
        end
    end

    // Strobes and sequencing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= nvmac_pkg::NVMAC_IDLE;
            write_strobe <= 1'b0;
            read_strobe <= 1'b0;
        end else begin
            case (state)
                nvmac_pkg::NVMAC_IDLE: begin
                    if (start_write) begin
                        write_strobe <= 1'b1;
                        state <= nvmac_pkg::NVMAC_WRITING;
                    end else if (start_read) begin
                        read_strobe <= 1'b1;
                        state <= nvmac_pkg::NVMAC_READING;
                    end
                end
                nvmac_pkg::NVMAC_WRITING: begin
                    // Timer done or aborted ends the write
                    if (timer_done || !timer_busy) begin
                        write_strobe <= 1'b0;
                        state <= nvmac_pkg::NVMAC_IDLE;
                    end
                end
                nvmac_pkg::NVMAC_READING: begin
                    read_strobe <= 1'b0;
                    state <= nvmac_pkg::NVMAC_IDLE;
                end
                default: begin
                    state <= nvmac_pkg::NVMAC_IDLE;
                end
            endcase
        end
    end

    // CPU stall counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stall_count <= 3'h0;
        end else if (start_write) begin
            stall_count <= `NVMAC_WSTALL_CYCLES;
        end else if (start_read) begin
            stall_count <= `NVMAC_RSTALL_CYCLES;
        end else if (stall_count != 3'h0) begin
            stall_count <= stall_count - 3'h1;
        end
    end
    assign cpu_stall = (stall_count != 3'h0);

    assign ready_irq = global_irq_enable && ready_irq_enable && !write_strobe;

    // Array port: write request held while the write runs, read pulse in fetch cycle
    always_comb begin
        array_req.addr = nvm_address_reg;
        array_req.wdata = nvm_data_reg;
        array_req.wr = (state == nvmac_pkg::NVMAC_WRITING) && timer_busy;
        array_req.rd = (state == nvmac_pkg::NVMAC_READING);
    end

    // Read mux; reserved bits zero
    always_comb begin
        io_rdata = `NVMAC_ZERO_BYTE;
        if (io_req.offset == `NVMAC_OFF_CTRL) begin
            io_rdata = `NVMAC_CTRL_RESET;
            io_rdata[`NVMAC_BIT_RIE] = ready_irq_enable;
            io_rdata[`NVMAC_BIT_MWE] = master_write_enable;
            io_rdata[`NVMAC_BIT_WRITE] = write_strobe;
            io_rdata[`NVMAC_BIT_READ] = read_strobe;
        end else if (io_req.offset == `NVMAC_OFF_DATA) begin
            io_rdata = nvm_data_reg;
        end else if (io_req.offset == `NVMAC_OFF_ADDR_LO) begin
            io_rdata = nvm_address_reg[7:0];
        end else begin
            io_rdata[0] = nvm_address_reg[ADDR_W-1];
        end
    end
endmodule

// File: testbench/nvmac_access_checker.sv
// Purpose: port-level checks of the access block
// Assumes: one clock domain, offset 3 is the control register
// Notes: bound onto every nvmac_access instance
`timescale 1ns/10ps
module nvmac_access_checker #(
    parameter int RC_CYCLES = 2048
) (
    input wire logic clk,
    input wire logic reset,
    input wire nvmac_pkg::nvmac_io_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic global_irq_enable,
    input wire logic cpu_stall,
    input wire logic ready_irq,
    input wire logic rc_tick,
    input wire nvmac_pkg::nvmac_array_t array_req,
    input wire logic [7:0] array_rdata
);
    logic [15:0] tick_cnt;
    wire ctl = io_req.offset == 2'h3;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk or posedge reset) begin
        if (reset || !array_req.wr) tick_cnt <= 16'h0000;
        else if (rc_tick) tick_cnt <= tick_cnt + 16'h0001;
    end
    sequence s_stall2; cpu_stall [*2] ##1 !cpu_stall; endsequence
    sequence s_stall4; cpu_stall [*4] ##1 !cpu_stall; endsequence
    sequence s_mwe_set; io_req.wr && ctl && io_req.wdata == 8'h04; endsequence
    a_irq_level: assert property (ctl |-> ready_irq == (global_irq_enable && io_rdata[3] && !io_rdata[1]))
        else $error("ready interrupt level wrong");
    a_ctrl_reserved: assert property (ctl |-> io_rdata[7:4] == 4'h0)
        else $error("reserved control bits not zero");
    a_write_stall: assert property ($rose(array_req.wr) |-> s_stall2)
        else $error("write stall not two cycles");
    a_read_stall: assert property ($rose(array_req.rd) |-> s_stall4)
        else $error("read stall not four cycles");
    a_read_pulse: assert property (array_req.rd |=> !array_req.rd)
        else $error("read strobe not self clearing");
    a_strobe_gated: assert property (io_req.wr && ctl && io_req.wdata[1] && !io_rdata[2]
        && !array_req.wr |=> !array_req.wr)
        else $error("write started without master enable");
    a_mwe_timeout: assert property (s_mwe_set ##1 (ctl && !io_req.wr) [*5]
        |-> $past(io_rdata[2]) && !io_rdata[2])
        else $error("master enable timeout wrong");
    a_write_length: assert property (array_req.wr |-> tick_cnt <= RC_CYCLES)
        else $error("write ran past its tick count");
endmodule
bind nvmac_access nvmac_access_checker #(.RC_CYCLES(RC_CYCLES)) chk_u (.clk(clk),
    .reset(reset), .io_req(io_req), .io_rdata(io_rdata), .global_irq_enable(global_irq_enable),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq), .rc_tick(rc_tick), .array_req(array_req),
    .array_rdata(array_rdata));

// File: testbench/nvmac_array_model.sv
// Purpose: behavioural nonvolatile array with its RC tick source
// Assumes: tick every third clock
// Notes: idle read data is the inverse of the last byte shown
`timescale 1ns/10ps
module nvmac_array_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Array side
    input wire nvmac_pkg::nvmac_array_t array_req,
    output logic [7:0] array_rdata,
    output logic rc_tick
);
    logic [7:0] mem [512];
    logic [7:0] last;
    logic [1:0] div;
    assign array_rdata = array_req.rd ? mem[array_req.addr] : ~last;
    assign rc_tick = div == 2'h2;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) div <= 2'h0;
        else div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    end
    always_ff @(posedge clk) begin
        if (array_req.wr) mem[array_req.addr] <= array_req.wdata;
        last <= array_rdata;
    end
endmodule

// File: testbench/tb.sv
// Purpose: register-level tests of the access block
// Assumes: RC count shortened to 8 ticks
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module tb;
    logic clk, reset, gie, cpu_stall, ready_irq, rc_tick;
    nvmac_pkg::nvmac_io_t io_req;
    nvmac_pkg::nvmac_array_t array_req;
    logic [7:0] io_rdata, array_rdata, v;
    int failures, checked, n;
    nvmac_access #(.RC_CYCLES(8)) dut_u (.clk(clk), .reset(reset), .io_req(io_req),
        .io_rdata(io_rdata), .global_irq_enable(gie), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .rc_tick(rc_tick), .array_req(array_req), .array_rdata(array_rdata));
    nvmac_array_model arr_u (.clk(clk), .reset(reset), .array_req(array_req),
        .array_rdata(array_rdata), .rc_tick(rc_tick));
    task chk(input logic [18:0] seen, input logic [18:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task wr_reg(input logic [1:0] off, input logic [7:0] d);
        @(posedge clk);
        #1 io_req = '{off, 1'b1, 1'b0, d};
        @(posedge clk);
        #1 io_req.wr = 1'b0;
    endtask
    task rd_reg(input logic [1:0] off);
        io_req.offset = off;
        #1 v = io_rdata;
    endtask
    task wait_idle;
        n = 0;
        do begin
            @(posedge clk);
            #1 rd_reg(2'h3);
            n++;
        end while (v[1] !== 1'b0 && n < 200);
        if (n >= 200) begin
            failures++;
            test_done();
        end
    endtask
    // Ready enable rewritten with every control write, so it is carried along
    task nv_write(input logic [8:0] a, input logic [7:0] d, input logic rie);
        wr_reg(2'h0, {7'h00, a[8]});
        wr_reg(2'h1, a[7:0]);
        wr_reg(2'h2, d);
        wr_reg(2'h3, {4'h0, rie, 3'h4});
        wr_reg(2'h3, {4'h0, rie, 3'h2});
    endtask
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial begin
        reset = 1;
        gie = 0;
        io_req = '0;
        failures = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        #1 reset = 0;
        rd_reg(2'h3);
        chk(v, 8'h00);
        nv_write(9'h1FF, 8'hA5, 1'b0);
        chk(array_req, {9'h1FF, 8'hA5, 2'b10});
        rd_reg(2'h3);
        chk(v[1], 1'b1);
        wait_idle();
        chk(n >= 21, 1'b1);
        chk(arr_u.mem[9'h1FF], 8'hA5);
        wr_reg(2'h2, 8'h00);
        wr_reg(2'h3, 8'h01);
        @(posedge clk);
        #1 rd_reg(2'h2);
        chk(v, 8'hA5);
        rd_reg(2'h3);
        chk(v[0], 1'b0);
        wr_reg(2'h3, 8'h02);
        rd_reg(2'h3);
        chk(v[1], 1'b0);
        wr_reg(2'h3, 8'h04);
        rd_reg(2'h3);
        chk(v[2], 1'b1);
        repeat (5) @(posedge clk);
        #1 rd_reg(2'h3);
        chk(v[2], 1'b0);
        wr_reg(2'h3, 8'h02);
        chk(array_req.wr, 1'b0);
        gie = 1;
        wr_reg(2'h3, 8'h08);
        chk(ready_irq, 1'b1);
        nv_write(9'h010, 8'h3C, 1'b1);
        chk(ready_irq, 1'b0);
        wr_reg(2'h2, 8'h77);
        @(posedge clk);
        #1 rd_reg(2'h3);
        chk({v[1], array_req.wr}, 2'b00);
        chk(ready_irq, 1'b1);
        test_done();
    end
endmodule
